// ### hw/csf_status_bank.sv
// four-channel status register bank behind the shared channel select
// Summary of operation
// - lock-loss flag sets when lock drops after acquisition; reading register clears it.
// - signal-lost flag sets only after signal was detected and then lost.
// - status bit 7 high while data rate is within configured ppm tolerance.
// - status bit 6 high once equalizer adaptation has finished.
// - status bit 5 high when signal quality is insufficient for lock.
// - status bits 4 and 3 both show recovery lock, always identical.
// - status bit 2 high once enough transitions were seen for lock.
// - status bit 1 high when data rate exceeds oscillator upper limit.
// - broadcast select bit is stored but drives nothing; reads come from the picked channel.
`timescale 1ns/1ps
module csf_status_bank
  import csf_pkg::*;
(
  input  wire logic                ref_clk,        // 125 MHz clock
  input  wire logic                nrst,           // async reset, active low
  input  wire logic                regWrEn,        // one-cycle register write strobe
  input  wire logic                regRdEn,        // one-cycle register read strobe
  input  wire logic [7:0]          regAddr,        // register address
  input  wire logic [7:0]          regWrData,      // write data
  output logic      [7:0]          regRdData,      // read data, registered
  output logic                     sharedSpace,    // access goes to shared registers
  input  wire logic [NUM_CH-1:0]   lockPin,        // recovery lock per channel
  input  wire logic [NUM_CH-1:0]   sigDetPin,      // signal detect per channel
  input  wire logic [NUM_CH-1:0]   rateOkPin,      // rate within ppm tolerance
  input  wire logic [NUM_CH-1:0]   adaptDonePin,   // equalizer adaptation done
  input  wire logic [NUM_CH-1:0]   lockFailPin,    // quality too low for lock
  input  wire logic [NUM_CH-1:0]   transMetPin,    // transition count met
  input  wire logic [NUM_CH-1:0]   overRangePin    // oscillator_over_range
);
  logic [1:0]        channelPick_reg;
  logic              channelSpaceEnable_reg;
  logic              broadcastWrite_reg;
  logic [NUM_CH-1:0] lockSync1_reg, lockSync2_reg;
  logic [NUM_CH-1:0] sigSync1_reg, sigSync2_reg;
  logic [7:0]        stSync1_reg [NUM_CH];
  logic [7:0]        stSync2_reg [NUM_CH];
  logic [7:0]        chFlags [NUM_CH];
  logic [7:0]        chStatus [NUM_CH];
  logic [NUM_CH-1:0] flagRd;
  logic              chanRead;

  // select register is write-only; it always lives in the shared set
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      channelPick_reg        <= SELECT_RESET[1:0];
      channelSpaceEnable_reg <= SELECT_RESET[SEL_ENABLE_BIT];
      broadcastWrite_reg     <= SELECT_RESET[SEL_BCAST_BIT];
    end else if (regWrEn && regAddr == ADDR_SELECT) begin
      channelPick_reg        <= regWrData[1:0];
      channelSpaceEnable_reg <= regWrData[SEL_ENABLE_BIT];
      broadcastWrite_reg     <= regWrData[SEL_BCAST_BIT];
    end
  end

  // without the enable, every address belongs to the shared set
  assign sharedSpace = !channelSpaceEnable_reg || regAddr == ADDR_SELECT;
  assign chanRead    = regRdEn && !sharedSpace;

  // status pins come from the analog loop: two flops before use
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lockSync1_reg <= '0;
      lockSync2_reg <= '0;
      sigSync1_reg  <= '0;
      sigSync2_reg  <= '0;
    end else begin
      lockSync1_reg <= lockPin;
      lockSync2_reg <= lockSync1_reg;
      sigSync1_reg  <= sigDetPin;
      sigSync2_reg  <= sigSync1_reg;
    end
  end

  // per-channel status synchronisers and channel instances
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        stSync1_reg[c] <= STATUS_RESET;
        stSync2_reg[c] <= STATUS_RESET;
      end else begin
        stSync1_reg[c] <= {rateOkPin[c],
                           adaptDonePin[c],
                           lockFailPin[c],
                           2'b00,
                           transMetPin[c],
                           overRangePin[c],
                           1'b0};
        stSync2_reg[c] <= stSync1_reg[c];
      end
    end

    // reads touch only the picked channel, broadcast or not
    assign flagRd[c] = chanRead && regAddr == ADDR_FLAGS
                       && channelPick_reg == 2'(c);

    csf_channel u_ch (
      .ref_clk      (ref_clk),
      .nrst         (nrst),
      .lockIn       (lockSync2_reg[c]),
      .sigDetIn     (sigSync2_reg[c]),
      .statusIn     (stSync2_reg[c]),
      .flagsRdPulse (flagRd[c]),
      .flagsOut     (chFlags[c]),
      .statusOut    (chStatus[c])
    );
  end

  // read data mux; writes to both status registers have nothing to store
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (chanRead) begin
      if (regAddr == ADDR_FLAGS) begin
        regRdData <= chFlags[channelPick_reg];
      end else if (regAddr == ADDR_STATUS) begin
        regRdData <= chStatus[channelPick_reg];
      end else begin
        regRdData <= 8'h00;
      end
    end else if (regRdEn) begin
      regRdData <= 8'h00;  // shared set and 0xff read back as zero
    end
  end
endmodule : csf_status_bank

// ### hw/csf_pkg.sv
// shared constants for the channel status flag register bank
package csf_pkg;
  localparam int          NUM_CH          = 4;
  localparam logic [7:0]  ADDR_FLAGS      = 8'h01;  // channel_event_flags
  localparam logic [7:0]  ADDR_STATUS     = 8'h02;  // recovery_status
  localparam logic [7:0]  ADDR_SELECT     = 8'hFF;  // shared channel select
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [3:0]  SELECT_RESET    = 4'h0;
  localparam int          LOCKLOSS_BIT    = 4;
  localparam int          SIGLOST_BIT     = 0;
  localparam int          SEL_BCAST_BIT   = 3;
  localparam int          SEL_ENABLE_BIT  = 2;
  localparam int          ST_RATE_OK      = 7;
  localparam int          ST_ADAPT_DONE   = 6;
  localparam int          ST_LOCK_FAIL    = 5;
  localparam int          ST_LOCK_A       = 4;
  localparam int          ST_LOCK_B       = 3;
  localparam int          ST_TRANS_MET    = 2;
  localparam int          ST_OVER_RANGE   = 1;
endpackage : csf_pkg

// ### hw/csf_channel.sv
// one channel: sticky event flags and live status byte
`timescale 1ns/1ps
module csf_channel
  import csf_pkg::*;
(
  input  wire logic       ref_clk,       // system clock
  input  wire logic       nrst,          // async reset, active low
  input  wire logic       lockIn,        // synchronised recovery lock
  input  wire logic       sigDetIn,      // synchronised signal detect
  input  wire logic [7:0] statusIn,      // synchronised live status byte
  input  wire logic       flagsRdPulse,  // one-cycle read of flag register
  output logic      [7:0] flagsOut,      // channel_event_flags value
  output logic      [7:0] statusOut      // recovery_status value
);
  logic lockSeen_reg;
  logic sigSeen_reg;
  logic lockPrev_reg;
  logic sigPrev_reg;
  logic lockLost_reg;
  logic sigLost_reg;
  logic lockFall;
  logic sigFall;

  // armed only after first acquisition, so a never-locked channel stays quiet
  assign lockFall = lockPrev_reg && !lockIn && lockSeen_reg;
  assign sigFall  = sigPrev_reg && !sigDetIn && sigSeen_reg;

  // history of acquisition and previous level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lockSeen_reg <= 1'b0;
      sigSeen_reg  <= 1'b0;
      lockPrev_reg <= 1'b0;
      sigPrev_reg  <= 1'b0;
    end else begin
      lockPrev_reg <= lockIn;
      sigPrev_reg  <= sigDetIn;
      if (lockIn) lockSeen_reg <= 1'b1;
      if (sigDetIn) sigSeen_reg <= 1'b1;
    end
  end

  // lock-loss flag: set beats the clear-on-read in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lockLost_reg <= 1'b0;
    end else if (lockFall) begin
      lockLost_reg <= 1'b1;
    end else if (flagsRdPulse) begin
      lockLost_reg <= 1'b0;
    end
  end

  // signal-lost flag is sticky; it has no documented clear so it holds until reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sigLost_reg <= 1'b0;
    end else if (sigFall) begin
      sigLost_reg <= 1'b1;
    end
  end

  // flag byte, reserved bits zero
  always_comb begin
    flagsOut               = FLAGS_RESET;
    flagsOut[LOCKLOSS_BIT] = lockLost_reg;
    flagsOut[SIGLOST_BIT]  = sigLost_reg;
  end

  // live status, both lock copies come from one source so they never differ
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      statusOut <= STATUS_RESET;
    end else begin
      statusOut                <= statusIn;
      statusOut[ST_LOCK_A]     <= lockIn;
      statusOut[ST_LOCK_B]     <= lockIn;
      statusOut[0]             <= 1'b0;
    end
  end
endmodule : csf_channel

// ### dv/csf_status_bank_assertions.sv
// port-level checker for the channel status register bank
`timescale 1ns/1ps
module csf_status_bank_assertions
  import csf_pkg::*;
(
  input wire logic       ref_clk,     // clock
  input wire logic       nrst,        // reset, active low
  input wire logic       regWrEn,     // write strobe
  input wire logic       regRdEn,     // read strobe
  input wire logic [7:0] regAddr,     // address
  input wire logic [7:0] regWrData,   // write data
  input wire logic [7:0] regRdData,   // read data
  input wire logic       sharedSpace  // shared decode
);
  logic [3:0] selReg;
  // shadow of the select register, since it cannot be read back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) selReg <= SELECT_RESET;
    else if (regWrEn && regAddr == ADDR_SELECT) selReg <= regWrData[3:0];
  end
  wire chanRd = regRdEn && selReg[SEL_ENABLE_BIT] && regAddr != ADDR_SELECT;
  sequence s_stat_rd;
    chanRd && regAddr == ADDR_STATUS;
  endsequence
  sequence s_flag_rd;
    chanRd && regAddr == ADDR_FLAGS;
  endsequence
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_shared_zero: assert property (regRdEn && !selReg[SEL_ENABLE_BIT] |=> regRdData == 8'h00)
    else $error("shared read not zero");
  a_select_unread: assert property (regRdEn && regAddr == ADDR_SELECT |=> regRdData == 8'h00)
    else $error("select read not zero");
  a_space_decode: assert property (sharedSpace == (!selReg[SEL_ENABLE_BIT] || regAddr == ADDR_SELECT))
    else $error("shared space decode wrong");
  a_lock_pair: assert property (s_stat_rd |=> regRdData[ST_LOCK_A] == regRdData[ST_LOCK_B])
    else $error("lock bits differ");
  a_stat_bit0: assert property (s_stat_rd |=> !regRdData[0])
    else $error("status bit0 set");
  a_flag_reserved: assert property (s_flag_rd |=> (regRdData & 8'hEE) == 8'h00)
    else $error("reserved flag bits set");
  a_unmapped_zero: assert property (chanRd && regAddr > ADDR_STATUS |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without read");
endmodule : csf_status_bank_assertions
bind csf_status_bank csf_status_bank_assertions chk (.ref_clk(ref_clk), .nrst(nrst),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .sharedSpace(sharedSpace));

// ### dv/csf_host_model.sv
// register host model driving the bank at the falling edge
`timescale 1ns/1ps
module csf_host_model (
  input  wire logic       ref_clk,   // clock
  input  wire logic [7:0] regRdData, // read data
  output logic            regWrEn,   // write strobe
  output logic            regRdEn,   // read strobe
  output logic      [7:0] regAddr,   // address
  output logic      [7:0] regWrData  // write data
);
  initial begin
    {regWrEn, regRdEn, regAddr, regWrData} = 18'h0;
  end
  // idle bus lines are inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk) {regWrEn, regAddr, regWrData} <= {1'b1, a, d};
    @(negedge ref_clk) {regWrEn, regAddr, regWrData} <= {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk) {regRdEn, regAddr} <= {1'b1, a};
    @(negedge ref_clk) {regRdEn, regAddr} <= {1'b0, ~a};
    d = regRdData;
  endtask : rd
endmodule : csf_host_model

// ### dv/csf_status_bank_bench.sv
// self-checking bench for the channel status register bank
`timescale 1ns/1ps
module csf_status_bank_bench;
  import csf_pkg::*;
  logic       ref_clk = 1'b0, nrst = 1'b0, regWrEn, regRdEn, sharedSpace;
  logic [7:0] regAddr, regWrData, regRdData, got;
  logic [3:0] lockPin = 4'h0, sigDetPin = 4'h0, rateOkPin = 4'h0, adaptDonePin = 4'h0;
  logic [3:0] lockFailPin = 4'h0, transMetPin = 4'h0, overRangePin = 4'h0;
  logic [31:0] rnd = 32'h56243D04;
  int failures = 0, samples_checked = 0, cycles = 0;
  csf_status_bank uut (.ref_clk(ref_clk), .nrst(nrst), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .sharedSpace(sharedSpace),
    .lockPin(lockPin), .sigDetPin(sigDetPin), .rateOkPin(rateOkPin), .adaptDonePin(adaptDonePin),
    .lockFailPin(lockFailPin), .transMetPin(transMetPin), .overRangePin(overRangePin));
  csf_host_model host (.ref_clk(ref_clk), .regRdData(regRdData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // live status byte for one channel, bit0 always reads zero
  function automatic logic [7:0] expSt(input int c);
    return {rateOkPin[c], adaptDonePin[c], lockFailPin[c], lockPin[c], lockPin[c],
            transMetPin[c], overRangePin[c], 1'b0};
  endfunction : expSt
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // cycle ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    // release off the sampling edge so no flop races the reset removal
    @(negedge ref_clk) nrst = 1'b1;
    host.rd(ADDR_FLAGS, got); chk("shared flags", got, 8'h00);
    for (int c = 0; c < NUM_CH; c++) begin
      host.wr(ADDR_SELECT, 8'h04 | c[7:0]);
      host.rd(ADDR_FLAGS, got); chk("flags idle", got, FLAGS_RESET);
      chk("space chan", {7'h00, sharedSpace}, 8'h00);
    end
    // acquire then lose lock and signal on every channel
    lockPin = 4'hF; sigDetPin = 4'hF;
    repeat (6) @(negedge ref_clk);
    host.rd(ADDR_FLAGS, got); chk("flags locked", got, 8'h00);
    lockPin = 4'h0; sigDetPin = 4'h0;
    repeat (6) @(negedge ref_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      host.wr(ADDR_SELECT, 8'h0C | c[7:0]);
      host.rd(ADDR_FLAGS, got); chk("flags lost", got, 8'h11);
      host.rd(ADDR_FLAGS, got); chk("flags reread", got, 8'h01);
    end
    host.rd(8'h03, got); chk("unmapped", got, 8'h00);
    host.rd(ADDR_SELECT, got); chk("select", got, 8'h00);
    // random status levels, channel and broadcast choice, with ignored status writes
    for (int i = 0; i < 24; i++) begin
      rnd = xs(rnd);
      {lockPin, rateOkPin, adaptDonePin, lockFailPin, transMetPin, overRangePin} = rnd[23:0];
      host.wr(ADDR_SELECT, {4'h0, rnd[27], 1'b1, rnd[25:24]});
      host.wr(ADDR_STATUS, ~expSt(rnd[25:24]));
      repeat (4) @(negedge ref_clk);
      host.rd(ADDR_STATUS, got); chk("status", got, expSt(rnd[25:24]));
    end
    // mid-run reset drops the select and forgets acquisition history
    @(negedge ref_clk) nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    chk("space reset", {7'h00, sharedSpace}, 8'h01);
    host.wr(ADDR_SELECT, 8'h04);
    host.rd(ADDR_FLAGS, got); chk("flags reset", got, FLAGS_RESET);
    summarize();
  end
endmodule : csf_status_bank_bench
